// ==== rtl/wdt_skip_pkg.sv ====
package wdt_skip_pkg;
  localparam int DW = 8;
  localparam int IW = 16;
  localparam int AW = 12;
  localparam int BW = 4;
  localparam int SW = 4;
  // opcode field positions and values
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int F_MSB    = 7;
  localparam logic [IW-1:0] KICK_WORD = 16'h0004;
  localparam logic [5:0]    INV_TOP   = 6'h07;
  localparam logic [6:0]    SEQ_TOP   = 7'h31;
  localparam logic [6:0]    SGT_TOP   = 7'h32;
  localparam logic [6:0]    SLT_TOP   = 7'h30;
  localparam logic [BW-1:0] ACCESS_BANK = 4'h0;
  // status bit positions and reset value
  localparam int ST_NULL = 0;
  localparam int ST_MSB  = 1;
  localparam int ST_WDX  = 2;
  localparam int ST_SLP  = 3;
  localparam logic [SW-1:0] STAT_RST = 4'hC;
  // apb map
  localparam int PAW = 8;
  localparam logic [PAW-1:0] ACC_OFS  = 8'h00;
  localparam logic [PAW-1:0] STAT_OFS = 8'h04;
  localparam logic [PAW-1:0] BANK_OFS = 8'h08;
  localparam logic [PAW-1:0] WDT_OFS  = 8'h0C;
  localparam logic [PAW-1:0] INFO_OFS = 8'h10;

  typedef enum logic [1:0] {
    Q1 = 2'b00, Q2 = 2'b01, Q3 = 2'b11, Q4 = 2'b10
  } phase_type;

  typedef struct packed {
    logic          kick;
    logic          invert;
    logic          seq;
    logic          sgt;
    logic          slt;
    logic          dest;
    logic          banked;
    logic [DW-1:0] f;
  } dec_type;

  typedef struct packed {
    logic [DW-1:0] inv;
    logic          eq;
    logic          gt;
    logic          lt;
  } alu_type;

  function automatic dec_type decode(input logic [IW-1:0] w);
    dec_type d;
    d.kick   = (w == KICK_WORD);
    d.invert = (w[IW-1:IW-6] == INV_TOP);
    d.seq    = (w[IW-1:IW-7] == SEQ_TOP);
    d.sgt    = (w[IW-1:IW-7] == SGT_TOP);
    d.slt    = (w[IW-1:IW-7] == SLT_TOP);
    d.dest   = w[DEST_BIT];
    d.banked = w[BANK_BIT];
    d.f      = w[F_MSB:0];
    return d;
  endfunction : decode
endpackage : wdt_skip_pkg

// ==== rtl/phase_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module phase_seq (
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  output var  wdt_skip_pkg::phase_type phase
);
  import wdt_skip_pkg::*;
  phase_type phase_reg;
  phase_type phase_next;

  always_comb begin
    case (phase_reg)
      Q1:      phase_next = Q2;
      Q2:      phase_next = Q3;
      Q3:      phase_next = Q4;
      default: phase_next = Q1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) phase_reg <= Q1;
    else        phase_reg <= phase_next;
  end

  assign phase = phase_reg;
endmodule : phase_seq
`default_nettype wire

// ==== rtl/cmp_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmp_unit (
  input  wire logic [wdt_skip_pkg::DW-1:0] opnd,
  input  wire logic [wdt_skip_pkg::DW-1:0] acc,
  output var  wdt_skip_pkg::alu_type       res
);
  import wdt_skip_pkg::*;
  logic [DW:0] diff;

  // one subtractor serves all three compares, unsigned
  assign diff   = {1'b0, opnd} - {1'b0, acc};
  assign res.inv = ~opnd;
  assign res.eq  = (diff == '0);
  assign res.lt  = diff[DW];
  assign res.gt  = !res.lt && !res.eq;
endmodule : cmp_unit
`default_nettype wire

// ==== rtl/wdt_skip_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdt_skip_exec #(
  parameter int WDT_W  = 8,
  parameter int POST_W = 7
) (
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic [wdt_skip_pkg::IW-1:0] instr_word,
  input  wire logic                        instr_two_word,
  output logic                             instr_ready,
  output logic [wdt_skip_pkg::AW-1:0]      mem_addr,
  input  wire logic [wdt_skip_pkg::DW-1:0] mem_rdata,
  output logic                             mem_we,
  output logic [wdt_skip_pkg::DW-1:0]      mem_wdata,
  output logic                             nop_active,
  output logic                             skip_pulse,
  input  wire logic                        wdt_tick,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [wdt_skip_pkg::PAW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr
);
  import wdt_skip_pkg::*;

  logic              rst_meta_reg;
  logic              rst_n_reg;
  phase_type         phase;
  dec_type           ir_reg;
  logic              nop_reg;
  logic              squash_reg;
  logic [DW-1:0]     opnd_reg;
  logic [DW-1:0]     res_reg;
  logic [DW-1:0]     acc_reg;
  logic [SW-1:0]     stat_reg;
  logic [SW-1:0]     stat_next;
  logic [BW-1:0]     bank_reg;
  logic [WDT_W-1:0]  wdt_cnt_reg;
  logic [POST_W-1:0] post_reg;
  logic [AW-1:0]     addr_reg;
  logic [31:0]       prdata_reg;
  logic              skip_reg;
  alu_type           alu;
  dec_type           dec_in;

  // reset release through two flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  phase_seq u_phase (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_reg),
    .phase   (phase)
  );

  cmp_unit u_cmp (
    .opnd (opnd_reg),
    .acc  (acc_reg),
    .res  (alu)
  );

  // decode and phase strobes
  wire q1 = (phase == Q1);
  wire q2 = (phase == Q2);
  wire q3 = (phase == Q3);
  wire q4 = (phase == Q4);
  assign dec_in = decode(instr_word);
  wire live      = !nop_reg;
  wire do_kick   = q4 && live && ir_reg.kick;
  wire do_inv    = q4 && live && ir_reg.invert;
  wire is_cmp    = ir_reg.seq || ir_reg.sgt || ir_reg.slt;
  wire cmp_hit   = (ir_reg.seq && alu.eq) ||
                   (ir_reg.sgt && alu.gt) ||
                   (ir_reg.slt && alu.lt);
  wire do_skip   = q4 && live && is_cmp && cmp_hit;
  wire inv_acc   = do_inv && !ir_reg.dest;
  wire inv_mem   = do_inv && ir_reg.dest;
  // a zero bank choice ignores the bank select register
  wire [BW-1:0] bank_use = dec_in.banked ? bank_reg : ACCESS_BANK;
  wire post_wrap = (post_reg == {POST_W{1'b1}});

  // apb decode
  wire apb_setup = psel && !penable;
  wire apb_acc   = psel && penable;
  wire hit_acc   = (paddr == ACC_OFS);
  wire hit_stat  = (paddr == STAT_OFS);
  wire hit_bank  = (paddr == BANK_OFS);
  wire hit_wdt   = (paddr == WDT_OFS);
  wire hit_info  = (paddr == INFO_OFS);
  wire hit_any   = hit_acc || hit_stat || hit_bank || hit_wdt || hit_info;
  wire wr_ok     = apb_acc && pwrite && hit_any;
  wire wr_acc    = wr_ok && hit_acc;
  wire wr_stat   = wr_ok && hit_stat;
  wire wr_bank   = wr_ok && hit_bank;
  wire [31:0] rd_mux =
    hit_acc  ? {{(32-DW){1'b0}}, acc_reg} :
    hit_stat ? {{(32-SW){1'b0}}, stat_reg} :
    hit_bank ? {{(32-BW){1'b0}}, bank_reg} :
    hit_wdt  ? {{(32-WDT_W-POST_W){1'b0}}, wdt_cnt_reg, post_reg} :
    hit_info ? {28'h0000000, squash_reg, nop_reg, phase} : 32'h00000000;

  assign pready      = 1'b1;
  assign pslverr     = apb_acc && !hit_any;
  assign prdata      = prdata_reg;
  assign instr_ready = q1;
  assign mem_addr    = addr_reg;
  assign mem_we      = inv_mem;
  assign mem_wdata   = res_reg;
  assign nop_active  = nop_reg;
  assign skip_pulse  = skip_reg;

  // hardware updates win over a software write in the same cycle
  always_comb begin
    stat_next = wr_stat ? pwdata[SW-1:0] : stat_reg;
    if (do_kick) begin
      stat_next[ST_WDX] = 1'b1;
      stat_next[ST_SLP] = 1'b1;
    end
    if (do_inv) begin
      stat_next[ST_MSB]  = res_reg[DW-1];
      stat_next[ST_NULL] = (res_reg == '0);
    end
  end

  // fetch, skip bookkeeping
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ir_reg     <= '0;
      nop_reg    <= 1'b0;
      squash_reg <= 1'b0;
      addr_reg   <= '0;
      skip_reg   <= 1'b0;
    end else begin
      skip_reg <= do_skip;
      if (q1) begin
        ir_reg   <= dec_in;
        addr_reg <= {bank_use, dec_in.f};
        nop_reg  <= squash_reg;
        // a discarded two-word op drags its second word along, never a third
        if (squash_reg) squash_reg <= instr_two_word && !nop_reg;
      end
      if (do_skip) squash_reg <= 1'b1;
    end
  end

  // operand read and compute
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      opnd_reg <= '0;
      res_reg  <= '0;
    end else begin
      if (q2) opnd_reg <= mem_rdata;
      if (q3) res_reg <= alu.inv;
    end
  end

  // architectural state
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      acc_reg  <= '0;
      stat_reg <= STAT_RST;
      bank_reg <= '0;
    end else begin
      stat_reg <= stat_next;
      if (inv_acc) acc_reg <= res_reg;
      else if (wr_acc) acc_reg <= pwdata[DW-1:0];
      if (wr_bank) bank_reg <= pwdata[BW-1:0];
    end
  end

  // watchdog counter, kick beats a tick in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wdt_cnt_reg <= '0;
      post_reg    <= '0;
    end else if (do_kick) begin
      wdt_cnt_reg <= '0;
      post_reg    <= '0;
    end else if (wdt_tick) begin
      post_reg <= post_reg + 1'b1;
      if (post_wrap) wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
    end
  end

  // read data captured in setup so prdata is a flop
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg)     prdata_reg <= '0;
    else if (apb_setup) prdata_reg <= rd_mux;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_reg);

  kick_clear_a: assert property (do_kick |=> wdt_cnt_reg == '0 && post_reg == '0)
    else $error("kick did not clear watchdog");
  kick_flags_a: assert property (
    do_kick && !wr_stat |=> stat_reg[ST_WDX] && stat_reg[ST_SLP]
      && $stable(stat_reg[ST_MSB]) && $stable(stat_reg[ST_NULL]))
    else $error("kick flags wrong");
  invert_value_a: assert property (
    q3 && live && ir_reg.invert |=> ##1 (stat_reg[ST_NULL] == (opnd_reg == '1)
      || wr_stat))
    else $error("null flag wrong after invert");
  invert_dest_a: assert property (
    q3 && live && ir_reg.invert && !ir_reg.dest |=> ##1 acc_reg == ~opnd_reg && !$past(mem_we))
    else $error("invert to accumulator failed");
  bank_pick_a: assert property (
    q1 && !dec_in.banked |=> mem_addr[AW-1:DW] == ACCESS_BANK)
    else $error("access bank not used");
  cmp_quiet_a: assert property (
    q4 && live && is_cmp && !wr_stat |=> $stable(stat_reg))
    else $error("compare changed status");
  gt_skip_a: assert property (
    q4 && live && ir_reg.sgt && opnd_reg > acc_reg |=> squash_reg && skip_pulse)
    else $error("greater skip missed");
  lt_skip_a: assert property (
    q4 && live && ir_reg.slt && opnd_reg < acc_reg |=> squash_reg)
    else $error("less skip missed");
  skip_nop_a: assert property (skip_pulse |-> ##1 nop_reg [*4])
    else $error("skip did not squash next cycle");
  two_word_a: assert property (
    q1 && nop_reg == 1'b0 && squash_reg && instr_two_word |=> ##4 nop_reg [*4])
    else $error("second word not squashed");
  no_skip_a: assert property (
    q4 && live && is_cmp && !cmp_hit && !squash_reg |=> !squash_reg)
    else $error("compare skipped without cause");
  nop_quiet_a: assert property (nop_reg |-> !mem_we && !do_kick && !do_skip)
    else $error("squashed cycle had side effect");

  // phase-accurate checks, each tied to the cycle that does the work
  kick_timing_a: assert property (
    q1 && dec_in.kick && !squash_reg |=> ##2 do_kick)
    else $error("kick not executed in its own cycle");
  invert_msb_a: assert property (
    q3 && live && ir_reg.invert |=> ##1 stat_reg[ST_MSB] == !opnd_reg[DW-1])
    else $error("msb flag wrong after invert");
  invert_mem_a: assert property (
    q3 && live && ir_reg.invert && ir_reg.dest |=> mem_we && mem_wdata == ~opnd_reg)
    else $error("invert write-back failed");
  invert_keep_a: assert property (
    q4 && live && ir_reg.invert && ir_reg.dest && !wr_acc |=> $stable(acc_reg))
    else $error("write-back invert touched accumulator");
  bank_select_a: assert property (
    q1 && dec_in.banked |=> mem_addr[AW-1:DW] == $past(bank_reg))
    else $error("bank select register not used");
  eq_skip_a: assert property (
    q4 && live && ir_reg.seq && opnd_reg == acc_reg |=> squash_reg && skip_pulse)
    else $error("equal skip missed");
  squash_nop_a: assert property (
    q1 && squash_reg |=> nop_reg)
    else $error("discarded word was not squashed");
  single_squash_a: assert property (
    q1 && squash_reg && nop_reg |=> !squash_reg)
    else $error("more than two words squashed");
  skip_source_a: assert property (
    skip_pulse |-> $past(is_cmp) && $past(q4))
    else $error("skip without a compare");
  seq_decode_a: assert property (
    q1 && instr_word[IW-1:IW-7] == SEQ_TOP |=> ir_reg.seq && !ir_reg.sgt && !ir_reg.slt)
    else $error("equal compare not decoded");
  sgt_decode_a: assert property (
    q1 && instr_word[IW-1:IW-7] == SGT_TOP |=> ir_reg.sgt && !ir_reg.seq && !ir_reg.slt)
    else $error("greater compare not decoded");
  slt_decode_a: assert property (
    q1 && instr_word[IW-1:IW-7] == SLT_TOP |=> ir_reg.slt && !ir_reg.seq && !ir_reg.sgt)
    else $error("less compare not decoded");
  nop_state_a: assert property (
    nop_reg && !wr_acc && !wr_stat |=> $stable(acc_reg) && $stable(stat_reg))
    else $error("squashed cycle changed state");

  skip_seen_c: cover property (skip_pulse ##4 nop_reg);
  two_word_c: cover property (q1 && squash_reg && instr_two_word);
  kick_seen_c: cover property (do_kick);
  inv_mem_c: cover property (inv_mem);
  eq_skip_c: cover property (q4 && live && ir_reg.seq && cmp_hit);
endmodule : wdt_skip_exec
`default_nettype wire

// ==== testbench/fetch_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fetch_mem_model (
  input  wire logic                        ref_clk,
  input  wire logic                        instr_ready,
  input  wire logic [wdt_skip_pkg::AW-1:0] mem_addr,
  input  wire logic                        mem_we,
  input  wire logic [wdt_skip_pkg::DW-1:0] mem_wdata,
  output logic [wdt_skip_pkg::IW-1:0]      instr_word,
  output logic                             instr_two_word,
  output logic [wdt_skip_pkg::DW-1:0]      mem_rdata
);
  import wdt_skip_pkg::*;
  logic [DW-1:0] mem [2**AW];
  logic [IW:0]   prog [$];
  initial begin
    {instr_two_word, instr_word} = '0;
    for (int i = 0; i < 2**AW; i++) mem[i] = DW'(i * 37);
  end
  // one word ahead; empty queue feeds an ignored word
  always @(posedge ref_clk) begin
    if (instr_ready) {instr_two_word, instr_word} <= prog.size() ? prog.pop_front() : '0;
    if (mem_we) mem[mem_addr] <= mem_wdata;
  end
  assign mem_rdata = mem[mem_addr];
endmodule : fetch_mem_model
`default_nettype wire

// ==== testbench/wdt_clear_complement_compare_skip_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdt_clear_complement_compare_skip_tb;
  import wdt_skip_pkg::*;
  logic ref_clk, arst_n, wdt_tick, psel, penable, pwrite, pready, pslverr;
  logic instr_ready, instr_two_word, mem_we, nop_active, skip_pulse;
  logic [IW-1:0]  instr_word;
  logic [AW-1:0]  mem_addr, ma;
  logic [DW-1:0]  mem_rdata, mem_wdata, r, a;
  logic [PAW-1:0] paddr;
  logic [31:0]    pwdata, prdata;
  logic [32:0]    wr_q [$], rd_q [$];
  logic [3:0]     st;
  logic           sk, two;
  int failures, tests_run, cycles, nops, skips, enops, eskips, seed;

  wdt_skip_exec wdt_skip_exec_i (.ref_clk, .arst_n, .instr_word, .instr_two_word, .instr_ready,
    .mem_addr, .mem_rdata, .mem_we, .mem_wdata, .nop_active, .skip_pulse, .wdt_tick, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  fetch_mem_model fetch_mem_model_i (.ref_clk, .instr_ready, .mem_addr, .mem_we, .mem_wdata,
    .instr_word, .instr_two_word, .mem_rdata);

  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [32:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic wr, input logic [PAW-1:0] ad, input logic [32:0] d);
    if (!wr) rd_q.push_back(d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d[31:0];
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb

  // word queued for fetch only; drain waits for the queue to run out and then for four more fetch slots
  task automatic issue(input logic tw, input logic [IW-1:0] w);
    fetch_mem_model_i.prog.push_back({tw, w});
  endtask : issue

  task automatic drain;
    int n;
    n = 0;
    while (fetch_mem_model_i.prog.size()) @(posedge ref_clk);
    while (n < 4) begin
      @(posedge ref_clk);
      if (instr_ready) n++;
    end
  endtask : drain

  // marker: invert write-back in access bank, shows whether it ran
  task automatic marker(input logic tw, input logic [7:0] f, input logic run);
    issue(tw, {INV_TOP, 2'b10, f});
    if (run) begin
      r = ~fetch_mem_model_i.mem[{ACCESS_BANK, f}];
      wr_q.push_back({1'b0, ACCESS_BANK, f, r});
      st = {2'b11, r[7], r == 8'h00};
    end
  endtask : marker

  always @(posedge ref_clk) begin
    cycles++;
    nops += nop_active;
    skips += skip_pulse;
    if (mem_we) chk({1'b0, mem_addr, mem_wdata}, wr_q.size() ? wr_q.pop_front() : 'x);
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 'x);
    if (cycles > 30000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    seed = 79;
    arst_n = 0;
    {wdt_tick, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1;
    repeat (3) @(posedge ref_clk);
    apb(0, STAT_OFS, 33'(STAT_RST));
    apb(0, ACC_OFS, 33'h0);
    apb(0, 8'h14, 33'h1_0000_0000); // unmapped refused
    apb(1, BANK_OFS, 33'h5);
    // every destination and bank choice, all-ones hits the null flag
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'hFF : 8'($random(seed));
      ma = {i[1] ? 4'h5 : ACCESS_BANK, 8'h20};
      fetch_mem_model_i.mem[ma] = a;
      issue(0, {INV_TOP, i[0], i[1], 8'h20});
      if (i[0]) wr_q.push_back({1'b0, ma, ~a});
      st = {2'b11, ~a[7], a == 8'hFF};
      drain();
      apb(0, STAT_OFS, 33'(st));
      if (!i[0]) apb(0, ACC_OFS, {25'h0, ~a});
    end
    // three compares, random operands, equal every fourth pass
    for (int i = 0; i < 18; i++) begin
      r = 8'($random(seed));
      a = (i % 4 == 0) ? r : 8'($random(seed));
      two = 1'($random(seed));
      ma = {i[0] ? 4'h5 : ACCESS_BANK, 1'b0, 7'($random(seed))};
      fetch_mem_model_i.mem[ma] = r;
      apb(1, ACC_OFS, 33'(a));
      sk = (i % 3 == 0) ? r == a : (i % 3 == 1) ? r > a : r < a;
      issue(0, {(i % 3 == 0) ? SEQ_TOP : (i % 3 == 1) ? SGT_TOP : SLT_TOP, i[0], ma[7:0]});
      marker(two, 8'hF0, !sk);
      marker(0, 8'hF1, !(sk && two));
      enops += sk ? (two ? 8 : 4) : 0;
      eskips += sk;
      drain();
      apb(0, STAT_OFS, 33'(st));
    end
    chk(33'(nops), 33'(enops));
    chk(33'(skips), 33'(eskips));
    // postscaler wraps at 128 into the counter
    apb(1, STAT_OFS, 33'h3);
    wdt_tick <= 1;
    repeat (130) @(posedge ref_clk);
    wdt_tick <= 0;
    apb(0, WDT_OFS, 33'h82);
    issue(0, KICK_WORD);
    drain();
    apb(0, WDT_OFS, 33'h0);
    apb(0, STAT_OFS, 33'hF);
    wrap_up();
  end
endmodule : wdt_clear_complement_compare_skip_tb
`default_nettype wire
